//--- verilog/bss_pkg.sv
// shared constants and types for the bit-synchronous serial channel
package bss_pkg;

  // character geometry
  localparam int          MAX_LEN      = 9;               // longest character in bits
  localparam int          TX_SR_W      = MAX_LEN + 1;     // shift stages plus the end marker
  localparam int          LEN_W        = 4;               // width of the character length setting
  localparam logic [3:0]  LEN_NINE     = 4'h9;            // nine-bit character setting
  localparam logic [8:0]  SYNC_CHAR    = 9'h096;          // sync character, stage 9 in the msb

  // host accumulator mapping: stage 1 sits on host bit 11, stage 9 on host bit 3
  localparam int          ACC_W        = 12;
  localparam int          HOST_DATA_MSB = 11;

  // line levels
  localparam logic        MARK_LEVEL   = 1'b1;            // idle line holds mark

  // timing
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          RX_XFER_DELAY_NS  = 1000;       // wait before buffer transfer
  // least time, so round up
  localparam int          RX_XFER_DELAY_CYC =
    (RX_XFER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RX_TIMEOUT_NUM    = 3;          // timeout is 3/2 of a bit time
  localparam int          RX_TIMEOUT_DEN    = 2;
  localparam int          RX_BIT_NS_DEFAULT = 80;         // bit time of the receive clock

  // transmit modes
  typedef enum logic {
    TX_IDLE,
    TX_ACTIVE
  } bss_tx_mode_t;

endpackage

//--- verilog/bss_edge_sync.sv
// two-flop synchroniser for a pin, with a rising-edge pulse after it
`timescale 1ns/1ps
`default_nettype none

module bss_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // pin side
  input  wire logic pinIn,
  // synchronised side
  output logic      level,
  output logic      rise
);
  import bss_pkg::*;

  // whole state of the synchroniser
  typedef struct packed {
    logic meta;   // first stage, read only by the second
    logic sync;   // safe level
    logic prev;   // level one cycle back, for the edge
  } bss_sync_state_t;

  bss_sync_state_t state_ff;   // registered state
  bss_sync_state_t nxt_state;  // next state

  // next state: plain shift through the three stages
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = pinIn;
    nxt_state.sync = state_ff.meta;
    nxt_state.prev = state_ff.sync;
  end

  // register the state; reset clears every stage
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs never look at the first stage
  assign level = state_ff.sync;
  assign rise  = state_ff.sync & ~state_ff.prev;

endmodule

`default_nettype wire

//--- verilog/bss_channel.sv
// bit-synchronous serial channel: host instruction side, transmit and receive logic
//
// What this block does
// R1 - host load overwrites transmit holding buffer
// R2 - data line 1 is host bit 11, descending
// R3 - shift length follows char length; drive when active
// R4 - buffer to shift register sets end marker
// R5 - shift toward stage 1, zero into end
// R6 - flag sync character during each host load
// R7 - last bit when stages 3..9 and end zero
// R8 - last bit true after clear, end at 2
// R9 - receive clock shifts data into top stage
// R10 - sync detect, next shift arms receiver
// R11 - arming clears register, sentinel into input stage
// R12 - sentinel out, wait 1 us, buffer, flag
// R13 - each transfer inserts a fresh sentinel
// R14 - unread buffer overwritten, assembly continues
// R15 - read places buffer on host, clears flag
// R16 - skip only when receive flag clear
// R17 - shift restarts timer; timeout at 1.5 bits
// R18 - timeout ignored before sync, else disarms
// R19 - timeout sets end flag; skip and clear
// R20 - clear-active instruction disarms receiver
// R21 - power clear idles status flip-flops
// R22 - nine-bit sync 010010110, seen shifted once
// R23 - received characters arrive lsb first
// R24 - loading a sync character starts transmission
// R25 - after last bit reload buffer, request next
// R26 - serial clocks become single-cycle shift enables
`timescale 1ns/1ps
`default_nettype none

module bss_channel #(
  parameter int RX_BIT_NS = bss_pkg::RX_BIT_NS_DEFAULT  // receive bit time in ns
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // host instruction strobes, one cycle each
  input  wire logic                       powerClear,
  input  wire logic                       loadTxCharInstr,
  input  wire logic                       readRxBufInstr,
  input  wire logic                       skipRxFlagInstr,
  input  wire logic                       skipRxEndInstr,
  input  wire logic                       clearRxEndInstr,
  input  wire logic                       clearRxActiveInstr,
  // host data
  input  wire logic [bss_pkg::ACC_W-1:0]  hostAccBus,
  output logic      [bss_pkg::ACC_W-1:0]  hostInLines,
  output logic                            hostInValid,
  output logic                            hostSkip,
  // interrupt requests
  output logic                            rxIrqReq,
  output logic                            txIrqReq,
  // character length setting, 2 to 9
  input  wire logic [bss_pkg::LEN_W-1:0]  charLen,
  // data set
  input  wire logic                       txSerialClk,
  input  wire logic                       rxSerialClk,
  input  wire logic                       rxSerialData,
  output logic                            txSerialData,
  // status
  output logic                            txSyncSeen,
  output logic                            txLastBit,
  output logic                            rxArmed
);
  import bss_pkg::*;

  // receive timeout in cycles: longest time, so round down, never below one
  localparam int RX_TIMEOUT_RAW =
    (RX_BIT_NS * RX_TIMEOUT_NUM) / (RX_TIMEOUT_DEN * CLK_PERIOD_NS);
  localparam int RX_TIMEOUT_CYC = (RX_TIMEOUT_RAW < 1) ? 1 : RX_TIMEOUT_RAW;
  localparam int IDLE_CNT_W     = $clog2(RX_TIMEOUT_CYC + 1);
  localparam int XFER_CNT_W     = $clog2(RX_XFER_DELAY_CYC + 1);
  localparam logic [IDLE_CNT_W-1:0] IDLE_LAST = IDLE_CNT_W'(RX_TIMEOUT_CYC - 1);
  localparam logic [XFER_CNT_W-1:0] XFER_LAST = XFER_CNT_W'(RX_XFER_DELAY_CYC - 1);

  // whole state of the channel
  typedef struct packed {
    // transmit side
    logic [MAX_LEN-1:0]    txHoldBuf;      // parallel character from the host
    logic                  txCharPending;  // holding buffer has a fresh character
    logic                  txFlag;         // new character requested
    logic                  txSyncSeen;     // sync decoded on the last load, one cycle
    bss_tx_mode_t          txMode;         // idle or sending
    logic [TX_SR_W-1:0]    txShiftReg;     // bit 0 is stage 1, end marker above the char
    logic                  txDataOut;      // serial output line
    // receive side
    logic [MAX_LEN-1:0]    rxShiftReg;     // bit 0 is stage 1
    logic [MAX_LEN-1:0]    rxHoldBuf;      // character for the host
    logic [MAX_LEN-1:0]    rxPendChar;     // character waiting out the transfer delay
    logic                  rxArmed;        // receive active
    logic                  rxSyncOnce;     // a sync has been seen since the last timeout
    logic                  rxCharFlag;     // character ready
    logic                  rxStopFlag;     // receive clock has stopped
    logic                  rxXferBusy;     // transfer delay running
    logic [XFER_CNT_W-1:0] rxXferCnt;      // transfer delay count
    logic                  rxTimerRun;     // receive-in-progress timer running
    logic [IDLE_CNT_W-1:0] rxIdleCnt;      // cycles since the last receive shift
  } bss_state_t;

  bss_state_t           state_ff;      // registered state
  bss_state_t           nxt_state;     // next state
  logic                 txShiftPulse;  // one cycle per transmit clock rising edge
  logic                 rxShiftPulse;  // one cycle per receive clock rising edge
  logic                 rxDataSync;    // received bit, aligned with its clock
  logic [MAX_LEN-1:0]   hostOutLines;  // host accumulator bits in stage order
  logic [MAX_LEN-1:0]   lenMask;       // stages in use for this length
  logic [TX_SR_W-1:0]   endMarker;     // end marker just above the character
  logic [TX_SR_W-1:0]   lastBitMask;   // stages 3 up to the end marker
  logic [MAX_LEN-1:0]   rxSentinel;    // lone 1 in the input stage
  logic [MAX_LEN-1:0]   rxShifted;     // receive register after one shift
  logic                 txSyncMatch;   // host lines hold a sync character
  logic                 rxSyncDet;     // receive register holds sync, shifted once
  logic                 lastBit;       // transmit character fully sent

  // R26 serial clock enables
  bss_edge_sync txClkSync (
    .clk   (clk),
    .reset (reset),
    .pinIn (txSerialClk),
    .level (),
    .rise  (txShiftPulse)
  );

  // R26 receive clock enable
  bss_edge_sync rxClkSync (
    .clk   (clk),
    .reset (reset),
    .pinIn (rxSerialClk),
    .level (),
    .rise  (rxShiftPulse)
  );

  // data goes through the same depth as its clock, so both line up
  bss_edge_sync rxDataSyncInst (
    .clk   (clk),
    .reset (reset),
    .pinIn (rxSerialData),
    .level (rxDataSync),
    .rise  ()
  );

  // decoders and masks shared by both directions
  always_comb begin
    // R2 host bit mapping
    for (int i = 0; i < MAX_LEN; i++) begin
      hostOutLines[i] = hostAccBus[HOST_DATA_MSB - i];
    end
    lenMask     = MAX_LEN'((TX_SR_W'(1) << charLen) - TX_SR_W'(1));
    endMarker   = TX_SR_W'(1) << charLen;
    rxSentinel  = MAX_LEN'(endMarker >> 1);
    // R7 last bit decode, stages 3 and up through the end marker
    lastBitMask = ((endMarker << 1) - TX_SR_W'(1)) & ~TX_SR_W'(3);
    lastBit     = ~|(state_ff.txShiftReg & lastBitMask);
    // R6 sync decode of the character being loaded, low stages only
    txSyncMatch = ((hostOutLines ^ SYNC_CHAR) & lenMask) == '0;
    // R22 receive decoder looks for the sync one place shifted
    rxSyncDet   = ((state_ff.rxShiftReg ^ MAX_LEN'(SYNC_CHAR << 1)) & lenMask) == '0;
    // R9 new bit into the input stage, R23 so the lsb ends in stage 1
    rxShifted   = (state_ff.rxShiftReg >> 1) | (rxDataSync ? rxSentinel : '0);
  end

  // next-state logic: host flag clears come first, so a set in the same cycle wins; the load follows the transmit edge; power clear comes last and wins
  always_comb begin
    nxt_state            = state_ff;
    nxt_state.txSyncSeen = 1'b0;

    // R15 reading the buffer clears the character flag
    if (readRxBufInstr) begin
      nxt_state.rxCharFlag = 1'b0;
    end
    // R19 end flag cleared by the host
    if (clearRxEndInstr) begin
      nxt_state.rxStopFlag = 1'b0;
    end
    // R20 host disarms the receiver
    if (clearRxActiveInstr) begin
      nxt_state.rxArmed = 1'b0;
    end

    // transmit clock edge while sending
    if (txShiftPulse && state_ff.txMode == TX_ACTIVE) begin
      if (lastBit) begin
        if (state_ff.txCharPending) begin
          // R25 reload from the buffer and ask for the next
          // R4 end marker set on the reload
          nxt_state.txShiftReg    = TX_SR_W'(state_ff.txHoldBuf & lenMask) | endMarker;
          nxt_state.txCharPending = 1'b0;
          nxt_state.txFlag        = 1'b1;
        end else begin
          // host was late: message ends, line goes back to mark
          nxt_state.txMode = TX_IDLE;
        end
      end else begin
        // R5 shift toward stage 1, zero enters from the top
        nxt_state.txShiftReg = state_ff.txShiftReg >> 1;
      end
    end

    // host load of a transmit character; done after the edge so it is not lost
    if (loadTxCharInstr) begin
      // R1 straight overwrite, no clear first
      nxt_state.txHoldBuf     = hostOutLines;
      nxt_state.txCharPending = 1'b1;
      nxt_state.txFlag        = 1'b0;
      // R6 sync indication during the load
      nxt_state.txSyncSeen    = txSyncMatch;
      if (nxt_state.txMode == TX_IDLE && txSyncMatch) begin
        // R24 sync starts a transmission
        nxt_state.txMode     = TX_ACTIVE;
        // R8 cleared register reads as last bit sent
        nxt_state.txShiftReg = '0;
      end
    end

    // R3 drive stage 1 only while sending, mark otherwise
    nxt_state.txDataOut = (nxt_state.txMode == TX_ACTIVE) ?
                          nxt_state.txShiftReg[0] : MARK_LEVEL;

    if (rxShiftPulse) begin
      // R17 every shift restarts the receive-in-progress timer
      nxt_state.rxIdleCnt  = '0;
      nxt_state.rxTimerRun = 1'b1;
      if (!state_ff.rxArmed && rxSyncDet) begin
        // R10 shift after sync arms the receiver
        nxt_state.rxArmed    = 1'b1;
        nxt_state.rxSyncOnce = 1'b1;
        // R11 wipe the sync, sentinel into the input stage
        nxt_state.rxShiftReg = rxSentinel;
      end else if (state_ff.rxArmed && state_ff.rxShiftReg[0]) begin
        // R12 sentinel leaves stage 1: character complete, start the delay
        // the character is saved now, since shifting goes on during the delay
        nxt_state.rxPendChar = rxShifted;
        nxt_state.rxXferBusy = 1'b1;
        nxt_state.rxXferCnt  = '0;
        // R13 fresh sentinel, lower stages cleared so stage 1 only sees it
        nxt_state.rxShiftReg = rxSentinel;
      end else begin
        nxt_state.rxShiftReg = rxShifted;
      end
    end else if (state_ff.rxTimerRun) begin
      if (state_ff.rxIdleCnt == IDLE_LAST) begin
        nxt_state.rxTimerRun = 1'b0;
        // R18 timeout only counts once a sync has been seen
        if (state_ff.rxSyncOnce) begin
          nxt_state.rxArmed    = 1'b0;
          nxt_state.rxSyncOnce = 1'b0;
          // R19 timeout raises the end flag
          nxt_state.rxStopFlag = 1'b1;
        end
      end else begin
        nxt_state.rxIdleCnt = state_ff.rxIdleCnt + IDLE_CNT_W'(1);
      end
    end

    // transfer delay; a new completion during it simply restarts it
    if (state_ff.rxXferBusy && !(rxShiftPulse && nxt_state.rxXferCnt == '0 &&
                                 nxt_state.rxXferBusy && state_ff.rxShiftReg[0] &&
                                 state_ff.rxArmed)) begin
      if (state_ff.rxXferCnt == XFER_LAST) begin
        // R14 overwrite whatever the host left unread
        // R12 buffer the character and raise the flag
        nxt_state.rxHoldBuf  = state_ff.rxPendChar;
        nxt_state.rxCharFlag = 1'b1;
        nxt_state.rxXferBusy = 1'b0;
      end else begin
        nxt_state.rxXferCnt = state_ff.rxXferCnt + XFER_CNT_W'(1);
      end
    end

    // R21 power clear idles status and control; data registers other than the transmit shift register keep their contents
    if (powerClear) begin
      nxt_state.rxArmed       = 1'b0;
      nxt_state.rxSyncOnce    = 1'b0;
      nxt_state.rxCharFlag    = 1'b0;
      nxt_state.rxStopFlag    = 1'b0;
      nxt_state.rxXferBusy    = 1'b0;
      nxt_state.rxTimerRun    = 1'b0;
      nxt_state.txMode        = TX_IDLE;
      nxt_state.txCharPending = 1'b0;
      nxt_state.txFlag        = 1'b0;
      nxt_state.txShiftReg    = '0;
      nxt_state.txDataOut     = MARK_LEVEL;
    end
  end

  // register the whole state; line idles at mark from reset
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff           <= '0;
      state_ff.txDataOut <= MARK_LEVEL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // host read lines always show the buffer; valid marks the read cycle
  always_comb begin
    hostInLines = '0;
    // R15 buffer onto the host input lines, stage 1 on bit 11
    for (int i = 0; i < MAX_LEN; i++) begin
      hostInLines[HOST_DATA_MSB - i] = state_ff.rxHoldBuf[i];
    end
  end

  assign hostInValid  = readRxBufInstr;
  // R16 skip only while the tested flag is clear
  assign hostSkip     = (skipRxFlagInstr & ~state_ff.rxCharFlag) |
                        (skipRxEndInstr & ~state_ff.rxStopFlag);
  assign rxIrqReq     = state_ff.rxCharFlag | state_ff.rxStopFlag;
  assign txIrqReq     = state_ff.txFlag;
  assign txSerialData = state_ff.txDataOut;
  assign txSyncSeen   = state_ff.txSyncSeen;
  assign txLastBit    = lastBit;
  assign rxArmed      = state_ff.rxArmed;

endmodule

`default_nettype wire

//--- verif/bss_channel_sva.sv
// port-level checks for the bit-synchronous serial channel
`timescale 1ns/1ps
`default_nettype none
module bss_channel_sva import bss_pkg::*; #(
  parameter int RX_BIT_NS = 80  // receive bit time in ns
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             reset,
  // host strobes and data
  input wire logic             powerClear,
  input wire logic             loadTxCharInstr,
  input wire logic             readRxBufInstr,
  input wire logic             skipRxFlagInstr,
  input wire logic             skipRxEndInstr,
  input wire logic             clearRxActiveInstr,
  input wire logic [ACC_W-1:0] hostAccBus,
  input wire logic [LEN_W-1:0] charLen,
  // answers, link and status
  input wire logic             hostSkip,
  input wire logic             rxIrqReq,
  input wire logic             txIrqReq,
  input wire logic             rxSerialClk,
  input wire logic             txSyncSeen,
  input wire logic             txLastBit,
  input wire logic             rxArmed
);
  // idle allowance: 1.5 bits plus synchroniser and edge slack
  localparam int TO_LIM = RX_BIT_NS * 3 / 20 + 8;
  logic       rxClk_ff;    // last receive clock level
  logic [7:0] idleCnt_ff;  // cycles since the receive clock moved
  logic       syncLoad;    // host load carrying the nine-bit sync
  // stage 1 sits on host bit 11, so compare bit-reversed
  always_comb begin
    syncLoad = loadTxCharInstr && charLen == LEN_NINE;
    for (int i = 0; i < 9; i++) begin
      if (hostAccBus[11-i] != SYNC_CHAR[i]) syncLoad = 1'b0;
    end
  end
  // saturating, so a long idle never wraps back to a small count
  always_ff @(posedge clk) begin
    rxClk_ff <= rxSerialClk;
    if (reset || rxSerialClk != rxClk_ff) idleCnt_ff <= 8'h00;
    else if (idleCnt_ff != 8'hff) idleCnt_ff <= idleCnt_ff + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_skip_clear: assert property (skipRxFlagInstr && !rxIrqReq |-> hostSkip)
    else $error("no skip while receive flag clear");
  chk_flag_irq: assert property (skipRxFlagInstr && !hostSkip |-> rxIrqReq)
    else $error("receive flag set without interrupt");
  chk_end_irq: assert property (skipRxEndInstr && !hostSkip |-> rxIrqReq)
    else $error("end flag set without interrupt");
  chk_read_drop: assert property (readRxBufInstr && skipRxEndInstr && hostSkip
    && !skipRxFlagInstr |=> !rxIrqReq)
    else $error("read left the interrupt up");
  chk_sync_pulse: assert property (syncLoad |=> txSyncSeen ##1 !txSyncSeen)
    else $error("sync load not flagged for one cycle");
  chk_sync_last: assert property (syncLoad && txLastBit |=> txLastBit)
    else $error("last bit lost at transmission start");
  chk_rx_timeout: assert property (idleCnt_ff == TO_LIM |-> !rxArmed)
    else $error("receiver still armed after clock stop");
  chk_arm_clock: assert property ($rose(rxArmed) |-> idleCnt_ff < 8)
    else $error("receiver armed without a shift");
  chk_pclear_idle: assert property (powerClear |=> !rxArmed && !rxIrqReq && !txIrqReq)
    else $error("power clear left status set");
  chk_cra_disarm: assert property (clearRxActiveInstr |=> !rxArmed)
    else $error("clear-active did not disarm");
endmodule
bind bss_channel bss_channel_sva #(.RX_BIT_NS(RX_BIT_NS)) u_sva (
  .clk, .reset, .powerClear, .loadTxCharInstr, .readRxBufInstr, .skipRxFlagInstr,
  .skipRxEndInstr, .clearRxActiveInstr, .hostAccBus, .charLen, .hostSkip, .rxIrqReq,
  .txIrqReq, .rxSerialClk, .txSyncSeen, .txLastBit, .rxArmed
);
`default_nettype wire

//--- verif/bss_dataset_model.sv
// data set model: serial clocks, receive data and transmit capture
`timescale 1ns/1ps
`default_nettype none
module bss_dataset_model (
  // serial clocks
  output logic      txSerialClk,
  output logic      rxSerialClk,
  // data lines
  output logic      rxSerialData,
  input  wire logic txSerialData
);
  logic txSeen[$];  // line level late in each transmit bit
  // clocks stand low outside frames
  initial begin
    txSerialClk = 1'b0;
    rxSerialClk = 1'b0;
    rxSerialData = 1'b0;
  end
  // one frame; the 3 ns offset keeps pin edges off system clock edges
  task automatic send_rx(input logic [26:0] bits);
    #3;
    for (int i = 0; i < 27; i++) begin
      rxSerialData = bits[i];
      #40 rxSerialClk = 1'b1;
      #40 rxSerialClk = 1'b0;
    end
    // no pull on the line, so show the inverse rather than the last bit
    rxSerialData = ~rxSerialData;
  endtask
  // n transmit clocks, sampling just before each following edge
  task automatic run_tx(input int n);
    #3;
    repeat (n) begin
      txSerialClk = 1'b1;
      #40 txSerialClk = 1'b0;
      #39 txSeen.push_back(txSerialData);
      #1;
    end
  endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the bit-synchronous serial channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bss_pkg::*;
  // strobe masks: load, read, skip flag, skip end, clear end, clear active, power clear
  localparam logic [6:0] LD = 7'h01, RD = 7'h02, SKF = 7'h04, SKE = 7'h08;
  localparam logic [6:0] CLE = 7'h10, CLEAR_RX_ACTIVE_INSTR = 7'h20, PWC = 7'h40;
  logic        clk, reset, sk, vld;
  logic [6:0]  ins;               // host instruction strobes
  logic [11:0] hostAccBus, hostInLines, got;
  logic [3:0]  charLen;
  logic        hostInValid, hostSkip, rxIrqReq, txIrqReq, txSerialClk, rxSerialClk;
  logic        rxSerialData, txSerialData, txSyncSeen, txLastBit, rxArmed;
  int          err_total, n_checks;

  bss_channel #(.RX_BIT_NS(80)) u_dut (
    .clk, .reset, .powerClear(ins[6]), .loadTxCharInstr(ins[0]), .readRxBufInstr(ins[1]),
    .skipRxFlagInstr(ins[2]), .skipRxEndInstr(ins[3]), .clearRxEndInstr(ins[4]),
    .clearRxActiveInstr(ins[5]), .hostAccBus, .hostInLines, .hostInValid, .hostSkip,
    .rxIrqReq, .txIrqReq, .charLen, .txSerialClk, .rxSerialClk, .rxSerialData,
    .txSerialData, .txSyncSeen, .txLastBit, .rxArmed
  );
  bss_dataset_model u_ds (.txSerialClk, .rxSerialClk, .rxSerialData, .txSerialData);

  // system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // stage 1 of a character goes to host bit 11
  function automatic logic [11:0] to_acc(input logic [8:0] c);
    to_acc = 12'h000;
    for (int i = 0; i < 9; i++) to_acc[11-i] = c[i];
  endfunction
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // bounded wait; running out ends the run
  task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && s !== lvl; i++) @(posedge clk);
    if (i == lim) begin
      chk(s, lvl);
      give_verdict();
    end
  endtask
  // one-cycle strobe; combinational answers are caught inside its cycle
  task automatic strobe(input logic [6:0] m, input logic [11:0] a = 12'h000);
    @(posedge clk);
    ins <= m;
    hostAccBus <= a;
    #1;
    sk = hostSkip;
    got = hostInLines;
    vld = hostInValid;
    @(posedge clk);
    ins <= 7'h00;
    #1;
  endtask
  // one framed character, optionally disarmed in mid-frame
  task automatic rx_frame(input logic [8:0] d, input logic cut);
    fork
      // the detector also wants stage 1 clear, so the bit just before the sync is a 0
      u_ds.send_rx({d, SYNC_CHAR, 9'h0ff});
      begin
        wait_lvl(rxArmed, 1'b1, 300);
        if (cut) begin
          strobe(CLEAR_RX_ACTIVE_INSTR);
          chk(rxArmed, 1'b0);
        end
      end
    join
    wait_lvl(rxArmed, 1'b0, 40);
  endtask
  task automatic poll_flag();
    sk = 1'b1;
    for (int i = 0; i < 80 && sk === 1'b1; i++) strobe(SKF);
    chk(sk, 1'b0);
  endtask
  task automatic t_pre_sync();
    u_ds.send_rx({27{1'b1}});
    repeat (40) @(posedge clk);
    strobe(SKE);
    chk(sk, 1'b1);
    chk(rxArmed, 1'b0);
    $display("pre_sync finished");
  endtask
  task automatic t_rx_char();
    rx_frame(9'h0b5, 1'b0);
    strobe(SKF);
    chk(sk, 1'b1);
    strobe(SKE);
    chk(sk, 1'b0);
    poll_flag();
    strobe(CLE);
    strobe(RD | SKE);
    chk(got, to_acc(9'h0b5));
    chk(vld, 1'b1);
    chk(sk, 1'b1);
    chk(rxIrqReq, 1'b0);
    $display("rx_char finished");
  endtask
  task automatic t_clear_active();
    rx_frame(9'h155, 1'b1);
    repeat (150) @(posedge clk);
    strobe(SKF);
    chk(sk, 1'b1);
    strobe(CLE);
    $display("clear_active finished");
  endtask
  task automatic t_overwrite();
    rx_frame(9'h1e1, 1'b0);
    poll_flag();
    rx_frame(9'h03c, 1'b0);
    repeat (120) @(posedge clk);
    strobe(PWC);
    chk(rxIrqReq, 1'b0);
    strobe(RD);
    chk(got, to_acc(9'h03c));
    $display("overwrite finished");
  endtask
  task automatic t_tx();
    logic [18:0] e;
    e = {1'b1, 9'h0a6, SYNC_CHAR};
    chk(txSerialData, 1'b1);
    strobe(LD, to_acc(SYNC_CHAR));
    chk(txSyncSeen, 1'b1);
    chk(txLastBit, 1'b1);
    chk(txSerialData, 1'b0);
    fork
      u_ds.run_tx(19);
      begin
        wait_lvl(txIrqReq, 1'b1, 40);
        strobe(LD, to_acc(9'h1ff));
        strobe(LD, to_acc(9'h0a6));
      end
    join
    chk(12'(u_ds.txSeen.size()), 12'd19);
    for (int i = 0; i < 19; i++) chk(u_ds.txSeen[i], e[i]);
    $display("tx_path finished");
  endtask
  // four-bit characters: sync, one data character, then back to mark
  task automatic t_tx_short();
    logic [8:0] e;
    e = {1'b1, 4'h9, 4'h6};
    @(posedge clk);
    charLen <= 4'h4;
    strobe(LD, to_acc(9'h006));
    chk(txSyncSeen, 1'b1);
    fork
      u_ds.run_tx(9);
      begin
        wait_lvl(txIrqReq, 1'b1, 40);
        strobe(LD, to_acc(9'h009));
      end
    join
    chk(12'(u_ds.txSeen.size()), 12'd28);
    for (int i = 0; i < 9; i++) chk(u_ds.txSeen[19+i], e[i]);
    $display("tx_short finished");
  endtask

  // main sequence
  initial begin
    err_total = 0;
    n_checks = 0;
    reset = 1'b1;
    ins = 7'h00;
    hostAccBus = 12'h000;
    charLen = LEN_NINE;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_pre_sync();
    t_rx_char();
    t_clear_active();
    t_overwrite();
    t_tx();
    t_tx_short();
    give_verdict();
  end
endmodule
`default_nettype wire
